// File: design/dei_top.sv
// edge interrupt controller for field inputs zero and one
// Overview of operation
// - only inputs zero and one raise interrupts
// - enable register, bit per channel, 1 enables
// - edge select register, bit per channel
// - select 0 falling edge, 1 rising edge
// - pending flags readable, 1 means interrupt occurred
// - write one clears flag, zero ignored
// - no new request while flag stays set
// - control registers read back written values
// - requests go out on shared line seven
`timescale 1ns/1ps
`include "dei_consts.svh"
module dei_top (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // avalon-mm slave
  input  wire logic [`DEI_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [3:0]             avs_byteenable,
  input  wire logic [`DEI_DATA_W-1:0] avs_writedata,
  output logic      [`DEI_DATA_W-1:0] avs_readdata,
  output logic                        avs_waitrequest,
  // field inputs
  input  wire logic                   fieldInputZero,
  input  wire logic                   fieldInputOne,
  // host interrupt
  output logic                        hostIrqLine7
);
  dei_pkg::dei_top_s st;
  dei_pkg::dei_top_s next_st;
  dei_chan_if        chan ();

  logic       wrOk;
  logic [1:0] clrBits;
  logic [1:0] rdClr;
  logic [1:0] setEv;

  function automatic logic hit(
    input logic [`DEI_ADDR_W-1:0] addr,
    input logic [`DEI_IDX_W-1:0]  idx
  );
    hit = (addr[`DEI_ADDR_W-1:`DEI_IDX_LSB] == idx);
  endfunction

  function automatic logic [7:0] zext(input logic [1:0] v);
    zext = {6'h00, v};
  endfunction

  // only two channels feed the detector
  dei_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .fieldIn ({fieldInputOne, fieldInputZero}),
    .chan    (chan)
  );

  dei_edge u_edge (
    .chan (chan)
  );

  assign chan.edgeSel = st.edgeSel;

  always_comb begin
    next_st = st;
    wrOk    = avs_write & avs_byteenable[0];
    clrBits = '0;
    rdClr   = '0;
    // flag set only when enabled and not already pending
    setEv   = chan.edgeHit & st.enable & ~st.pending;
    if (wrOk && hit(avs_address, `DEI_IDX_ENABLE)) begin
      next_st.enable = avs_writedata[`DEI_CH_MSB:0];
    end
    if (wrOk && hit(avs_address, `DEI_IDX_EDGE)) begin
      next_st.edgeSel = avs_writedata[`DEI_CH_MSB:0];
    end
    if (wrOk && hit(avs_address, `DEI_IDX_MASK)) begin
      next_st.evtMask = avs_writedata[`DEI_CH_MSB:0];
    end
    if (wrOk && hit(avs_address, `DEI_IDX_PENDING)) begin
      clrBits = avs_writedata[`DEI_CH_MSB:0];
    end
    if (avs_read && st.phase == dei_pkg::DEI_ANSWER &&
        hit(avs_address, `DEI_IDX_STATUS)) begin
      rdClr = 2'h3;
    end
    // set wins over a clear in the same cycle
    next_st.pending   = (st.pending & ~clrBits) | setEv;
    next_st.evtStatus = (st.evtStatus & ~rdClr) | setEv;
    unique case (st.phase)
      dei_pkg::DEI_IDLE: begin
        if (avs_read) begin
          next_st.phase = dei_pkg::DEI_ANSWER;
          if (hit(avs_address, `DEI_IDX_ENABLE)) begin
            next_st.readData = zext(st.enable);
          end else if (hit(avs_address, `DEI_IDX_EDGE)) begin
            next_st.readData = zext(st.edgeSel);
          end else if (hit(avs_address, `DEI_IDX_PENDING)) begin
            next_st.readData = zext(st.pending);
          end else if (hit(avs_address, `DEI_IDX_STATUS)) begin
            next_st.readData = zext(st.evtStatus);
          end else if (hit(avs_address, `DEI_IDX_MASK)) begin
            next_st.readData = zext(st.evtMask);
          end else begin
            next_st.readData = '0;
          end
        end
      end
      dei_pkg::DEI_ANSWER: begin
        next_st.phase = dei_pkg::DEI_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '{enable: `DEI_ENABLE_RST, edgeSel: `DEI_EDGE_RST,
              pending: `DEI_PEND_RST, evtStatus: `DEI_STATUS_RST,
              evtMask: `DEI_MASK_RST, phase: dei_pkg::DEI_IDLE,
              readData: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  // reads wait one cycle, writes complete at once
  assign avs_waitrequest = avs_read & (st.phase != dei_pkg::DEI_ANSWER);
  assign avs_readdata    = {24'h000000, st.readData};
  // level request while any unmasked flag or event is held
  assign hostIrqLine7 = |((st.pending | st.evtStatus) & st.evtMask);

  // checks
  logic wrEnable;
  logic wrEdge;
  logic wrPend;
  logic rdAns;
  assign wrEnable = wrOk && hit(avs_address, `DEI_IDX_ENABLE);
  assign wrEdge   = wrOk && hit(avs_address, `DEI_IDX_EDGE);
  assign wrPend   = wrOk && hit(avs_address, `DEI_IDX_PENDING);
  assign rdAns    = avs_read && !avs_waitrequest;

  a_enable_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrEnable |=> st.enable == $past(avs_writedata[1:0]))
    else $error("enable register did not take written value");

  a_edge_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    wrEdge |=> chan.edgeSel == $past(avs_writedata[1:0]))
    else $error("edge select did not take written value");

  a_fall_detect: assert property (
    @(posedge ref_clk) disable iff (rst)
    (chan.edgeHit[0] && !st.edgeSel[0]) |->
      (chan.prev[0] && !chan.level[0]))
    else $error("hit on channel zero without falling edge");

  a_rise_detect: assert property (
    @(posedge ref_clk) disable iff (rst)
    (chan.edgeHit[1] && st.edgeSel[1]) |->
      (!chan.prev[1] && chan.level[1]))
    else $error("hit on channel one without rising edge");

  a_flag_readback: assert property (
    @(posedge ref_clk) disable iff (rst)
    (avs_read && avs_waitrequest && hit(avs_address, `DEI_IDX_PENDING)
      && !setEv[0] && !st.pending[0]) |=>
      (rdAns && avs_readdata[0] == 1'b0))
    else $error("pending read answer wrong or late");

  a_w1c_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wrPend && avs_writedata[0] && !setEv[0]) |=> !st.pending[0])
    else $error("write one did not clear flag zero");

  a_w0_keep: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wrPend && !avs_writedata[1] && st.pending[1]) |=> st.pending[1])
    else $error("write zero disturbed flag one");

  a_flag_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    (st.pending[0] && !(wrPend && avs_writedata[0])) |=>
      (st.pending[0] && !$rose(st.evtStatus[0])))
    else $error("flag zero dropped or re-raised while set");

  a_read_answer: assert property (
    @(posedge ref_clk) disable iff (rst)
    (avs_read && avs_waitrequest && hit(avs_address, `DEI_IDX_ENABLE))
      |=> (rdAns && avs_readdata[1:0] == $past(st.enable)))
    else $error("enable readback wrong or late");

  a_irq_raise: assert property (
    @(posedge ref_clk) disable iff (rst)
    ($rose(st.pending[1]) && st.evtMask[1]) |-> hostIrqLine7)
    else $error("flag one set but irq line low");

  a_flag_cause: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(st.pending[0]) |->
      $past(chan.edgeHit[0] && st.enable[0]))
    else $error("flag zero set without enabled edge");

  a_disabled_quiet: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!st.enable[1] && !st.pending[1] && !wrEnable) |=> !st.pending[1])
    else $error("disabled channel one raised a flag");

  c_flag_set: cover property (
    @(posedge ref_clk) disable iff (rst)
    $rose(st.pending[0]) ##[1:20] hostIrqLine7);

  c_clear_flag: cover property (
    @(posedge ref_clk) disable iff (rst)
    st.pending[1] ##1 (wrPend && avs_writedata[1]) ##1 !st.pending[1]);

  c_both_pending: cover property (
    @(posedge ref_clk) disable iff (rst)
    st.pending == 2'h3);

  c_status_read: cover property (
    @(posedge ref_clk) disable iff (rst)
    rdAns && hit(avs_address, `DEI_IDX_STATUS) && st.evtStatus != 2'h0);

  c_fall_zero: cover property (
    @(posedge ref_clk) disable iff (rst)
    chan.edgeHit[0] && !st.edgeSel[0] && st.enable[0]);

  a_fall_one: assert property (
    @(posedge ref_clk) disable iff (rst)
    (chan.edgeHit[1] && !st.edgeSel[1]) |->
      (chan.prev[1] && !chan.level[1]))
    else $error("hit on channel one without falling edge");

  a_rise_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    (chan.edgeHit[0] && st.edgeSel[0]) |->
      (!chan.prev[0] && chan.level[0]))
    else $error("hit on channel zero without rising edge");

  a_hit_primed: assert property (
    @(posedge ref_clk) disable iff (rst)
    !chan.primed |-> (chan.edgeHit == 2'h0))
    else $error("edge hit before synchroniser filled");

  a_flag_cause_one: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(st.pending[1]) |->
      $past(chan.edgeHit[1] && st.enable[1]))
    else $error("flag one set without enabled edge");

  a_disabled_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!st.enable[0] && !st.pending[0] && !wrEnable) |=> !st.pending[0])
    else $error("disabled channel zero raised a flag");

  a_flag_set_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    (chan.edgeHit[0] && st.enable[0] && !st.pending[0]) |=> st.pending[0])
    else $error("enabled edge did not set flag zero");

  a_flag_set_one: assert property (
    @(posedge ref_clk) disable iff (rst)
    (chan.edgeHit[1] && st.enable[1] && !st.pending[1]) |=> st.pending[1])
    else $error("enabled edge did not set flag one");

  a_flag_hold_one: assert property (
    @(posedge ref_clk) disable iff (rst)
    (st.pending[1] && !(wrPend && avs_writedata[1])) |=>
      (st.pending[1] && !$rose(st.evtStatus[1])))
    else $error("flag one dropped or re-raised while set");

  a_w1c_clear_one: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wrPend && avs_writedata[1] && !setEv[1]) |=> !st.pending[1])
    else $error("write one did not clear flag one");

  a_w0_keep_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wrPend && !avs_writedata[0] && st.pending[0]) |=> st.pending[0])
    else $error("write zero disturbed flag zero");

  a_edge_readback: assert property (
    @(posedge ref_clk) disable iff (rst)
    (avs_read && avs_waitrequest && hit(avs_address, `DEI_IDX_EDGE))
      |=> (rdAns && avs_readdata[1:0] == $past(st.edgeSel)))
    else $error("edge select readback wrong or late");

  a_pend_readback: assert property (
    @(posedge ref_clk) disable iff (rst)
    (avs_read && avs_waitrequest && hit(avs_address, `DEI_IDX_PENDING))
      |=> (rdAns && avs_readdata[1:0] == $past(st.pending)))
    else $error("pending readback wrong or late");

  a_write_no_wait: assert property (
    @(posedge ref_clk) disable iff (rst)
    (avs_write && !avs_read) |-> !avs_waitrequest)
    else $error("write was made to wait");

  a_upper_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    avs_readdata[31:2] == 30'h0)
    else $error("read data carries bits beyond two channels");

  a_irq_raise_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    ($rose(st.pending[0]) && st.evtMask[0]) |-> hostIrqLine7)
    else $error("flag zero set but irq line low");

  a_irq_quiet: assert property (
    @(posedge ref_clk) disable iff (rst)
    ((st.pending | st.evtStatus) == 2'h0) |-> !hostIrqLine7)
    else $error("irq line high with nothing held");

  a_mask_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    (st.evtMask == 2'h0) |-> !hostIrqLine7)
    else $error("irq line high while fully masked");

  a_status_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    (rdAns && hit(avs_address, `DEI_IDX_STATUS) && setEv == 2'h0)
      |=> (st.evtStatus == 2'h0))
    else $error("status read did not clear events");

  a_enable_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !wrEnable |=> $stable(st.enable))
    else $error("enable changed without a write");

  a_edge_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !wrEdge |=> $stable(st.edgeSel))
    else $error("edge select changed without a write");

  a_byte_lane: assert property (
    @(posedge ref_clk) disable iff (rst)
    (avs_write && !avs_byteenable[0]) |=>
      ($stable(st.enable) && $stable(st.edgeSel)))
    else $error("write without lane zero changed a register");

  a_mask_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wrOk && hit(avs_address, `DEI_IDX_MASK)) |=>
      (st.evtMask == $past(avs_writedata[1:0])))
    else $error("mask register did not take written value");
endmodule

// File: design/dei_consts.svh
// register indices, field positions, reset values for the input irq block
`ifndef DEI_CONSTS_SVH
`define DEI_CONSTS_SVH
`define DEI_ADDR_W      12
`define DEI_IDX_W       10
`define DEI_IDX_LSB     2
`define DEI_CH_MSB      1
`define DEI_DATA_W      32
`define DEI_REG_W       8
`define DEI_IDX_ENABLE  10'h202
`define DEI_IDX_EDGE    10'h203
`define DEI_IDX_PENDING 10'h207
`define DEI_IDX_STATUS  10'h210
`define DEI_IDX_MASK    10'h211
`define DEI_ENABLE_RST  2'h0
`define DEI_EDGE_RST    2'h0
`define DEI_PEND_RST    2'h0
`define DEI_STATUS_RST  2'h0
`define DEI_MASK_RST    2'h3
`define DEI_SYNC_RST    2'h0
`define DEI_FILL_RST    2'h0
`define DEI_FILL_DONE   2'h3
`define DEI_FILL_STEP   2'h1
`endif

// File: design/dei_pkg.sv
// types shared by the input irq block
package dei_pkg;
  typedef enum logic {
    DEI_IDLE,
    DEI_ANSWER
  } dei_phase_e;

  typedef struct packed {
    logic [1:0] enable;
    logic [1:0] edgeSel;
    logic [1:0] pending;
    logic [1:0] evtStatus;
    logic [1:0] evtMask;
    dei_phase_e phase;
    logic [7:0] readData;
  } dei_top_s;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] level;
    logic [1:0] prev;
    logic [1:0] fill;
  } dei_sync_s;
endpackage

// File: design/dei_chan_if.sv
// signals between synchroniser, edge detector and control logic
`timescale 1ns/1ps
interface dei_chan_if;
  logic [1:0] level;
  logic [1:0] prev;
  logic       primed;
  logic [1:0] edgeSel;
  logic [1:0] edgeHit;
  modport sync (output level, prev, primed);
  modport det  (input level, prev, primed, edgeSel, output edgeHit);
  modport ctrl (input edgeHit, level, prev, output edgeSel);
endinterface

// File: design/dei_sync.sv
// two-stage synchroniser plus history stage for the two field inputs
`timescale 1ns/1ps
`include "dei_consts.svh"
module dei_sync (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // field inputs
  input  wire logic [1:0] fieldIn,
  // to edge detector
  dei_chan_if.sync        chan
);
  dei_pkg::dei_sync_s st;
  dei_pkg::dei_sync_s next_st;

  always_comb begin
    next_st       = st;
    next_st.meta  = fieldIn;
    next_st.level = st.meta;
    next_st.prev  = st.level;
    if (st.fill != `DEI_FILL_DONE) begin
      next_st.fill = st.fill + `DEI_FILL_STEP;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '{meta: `DEI_SYNC_RST, level: `DEI_SYNC_RST,
              prev: `DEI_SYNC_RST, fill: `DEI_FILL_RST};
    end else begin
      st <= next_st;
    end
  end

  // edges only count once history holds real samples
  assign chan.level  = st.level;
  assign chan.prev   = st.prev;
  assign chan.primed = (st.fill == `DEI_FILL_DONE);
endmodule

// File: design/dei_edge.sv
// per-channel edge detector with selectable polarity
`timescale 1ns/1ps
module dei_edge (
  // channel signals
  dei_chan_if.det chan
);
  logic [1:0] rise;
  logic [1:0] fall;

  always_comb begin
    rise = chan.level & ~chan.prev;
    fall = ~chan.level & chan.prev;
    chan.edgeHit = '0;
    if (chan.primed) begin
      // 1 picks rising, 0 picks falling
      chan.edgeHit = (chan.edgeSel & rise) | (~chan.edgeSel & fall);
    end
  end
endmodule

// File: sim/dei_field_model.sv
// model of the two isolated field input lines
`timescale 1ns/1ps
module dei_field_model (
  // clock
  input  wire logic ref_clk,
  // field lines
  output logic      lineZero,
  output logic      lineOne
);
  initial begin
    lineZero = 1'b0;
    lineOne  = 1'b0;
  end

  // new levels after an edge, held long enough to pass the synchroniser
  task automatic drive(input logic [1:0] v);
    @(posedge ref_clk);
    lineZero <= v[0];
    lineOne  <= v[1];
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

// File: sim/tb_top.sv
// register-level testbench for the field input irq block
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [11:0] avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [3:0]  avsBe;
  logic [31:0] avsWdata;
  logic [31:0] avsRdata;
  logic        waitReq;
  logic        irqLine;
  logic        fieldZero;
  logic        fieldOne;
  int          n_fail = 0;
  int          checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  dei_top dut (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .avs_address     (avsAddress),
    .avs_read        (avsRead),
    .avs_write       (avsWrite),
    .avs_byteenable  (avsBe),
    .avs_writedata   (avsWdata),
    .avs_readdata    (avsRdata),
    .avs_waitrequest (waitReq),
    .fieldInputZero  (fieldZero),
    .fieldInputOne   (fieldOne),
    .hostIrqLine7    (irqLine)
  );

  dei_field_model field (
    .ref_clk  (ref_clk),
    .lineZero (fieldZero),
    .lineOne  (fieldOne)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] b);
    @(posedge ref_clk);
    avsAddress <= a;
    avsWdata   <= d;
    avsBe      <= b;
    avsWrite   <= 1'b1;
    do @(posedge ref_clk); while (waitReq !== 1'b0);
    avsWrite <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    avsAddress <= a;
    avsRead    <= 1'b1;
    do @(posedge ref_clk); while (waitReq !== 1'b0);
    chk(avsRdata, exp);
    avsRead <= 1'b0;
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge ref_clk);
    chk({31'h0, irqLine}, {31'h0, exp});
  endtask

  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    n_fail++;
    give_verdict();
  end

  initial begin
    avsAddress <= 12'h000;
    avsRead    <= 1'b0;
    avsWrite   <= 1'b0;
    avsBe      <= 4'h0;
    avsWdata   <= 32'h0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // reset values and unmapped place
    rd_chk(12'h808, 32'h0);
    rd_chk(12'h80c, 32'h0);
    rd_chk(12'h81c, 32'h0);
    rd_chk(12'h840, 32'h0);
    rd_chk(12'h844, 32'h3);
    rd_chk(12'h900, 32'h0);
    irq_chk(1'b0);
    $display("test reset done");
    // control registers read back, lane 0 only
    bus_wr(12'h808, 32'h3, 4'h1);
    bus_wr(12'h80c, 32'h1, 4'h1);
    bus_wr(12'h808, 32'h0, 4'h2);
    rd_chk(12'h808, 32'h3);
    rd_chk(12'h80c, 32'h1);
    $display("test control done");
    // channel zero on rising edge
    field.drive(2'b01);
    rd_chk(12'h81c, 32'h1);
    irq_chk(1'b1);
    field.drive(2'b00);
    rd_chk(12'h840, 32'h1);
    bus_wr(12'h81c, 32'h0, 4'h1);
    rd_chk(12'h81c, 32'h1);
    irq_chk(1'b1);
    field.drive(2'b01);
    bus_wr(12'h81c, 32'h1, 4'h1);
    rd_chk(12'h81c, 32'h0);
    irq_chk(1'b0);
    rd_chk(12'h840, 32'h0);
    $display("test channel zero done");
    // channel one on falling edge, mask gating
    field.drive(2'b11);
    rd_chk(12'h81c, 32'h0);
    field.drive(2'b01);
    rd_chk(12'h81c, 32'h2);
    rd_chk(12'h840, 32'h2);
    irq_chk(1'b1);
    bus_wr(12'h844, 32'h0, 4'h1);
    irq_chk(1'b0);
    bus_wr(12'h844, 32'h3, 4'h1);
    irq_chk(1'b1);
    bus_wr(12'h81c, 32'h2, 4'h1);
    rd_chk(12'h81c, 32'h0);
    irq_chk(1'b0);
    $display("test channel one done");
    // disabled channels drop edges
    bus_wr(12'h808, 32'h0, 4'h1);
    bus_wr(12'h80c, 32'h3, 4'h1);
    field.drive(2'b00);
    field.drive(2'b11);
    rd_chk(12'h81c, 32'h0);
    rd_chk(12'h840, 32'h0);
    irq_chk(1'b0);
    $display("test disabled done");
    // channel zero on falling edge
    bus_wr(12'h80c, 32'h2, 4'h1);
    bus_wr(12'h808, 32'h1, 4'h1);
    field.drive(2'b10);
    rd_chk(12'h81c, 32'h1);
    rd_chk(12'h840, 32'h1);
    bus_wr(12'h81c, 32'h1, 4'h1);
    rd_chk(12'h81c, 32'h0);
    irq_chk(1'b0);
    $display("test channel zero falling done");
    give_verdict();
  end
endmodule
